// ### design/e8tc_prescaler.sv
// Eight-bit prescaler dividing count ticks by two up to 256 in powers of two.
`timescale 1ns/1ps
`default_nettype none
module e8tc_prescaler #(
   parameter int W = 8
) (
   input  wire logic                clk,    // Clock.
   input  wire logic                nrst,   // Synchronous reset, active low.
   input  wire logic                clr,    // Clears the internal count.
   input  wire logic                tick,   // One count clock event.
   input  wire logic                bypass, // High gives a 1:1 rate.
   input  wire e8tc_pkg::e8tc_rate_t rate,  // Division select.
   output logic                     inc     // One-cycle increment request.
);
   import e8tc_pkg::*;

   logic [W-1:0] cnt_q;
   logic [W-1:0] cnt_d;
   logic [W-1:0] mask;

   // Ratio 2^(rate+1): the pulse fires when the low rate+1 bits are all one.
   always_comb begin
      mask  = W'((9'h002 << rate) - 9'h001);
      cnt_d = cnt_q;
      if (clr) begin
         cnt_d = '0;
      end else if (tick && !bypass) begin
         cnt_d = cnt_q + W'(1);
      end
   end

   assign inc = !clr && tick && (bypass || ((cnt_q & mask) == mask));

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule
`default_nettype wire

// ### design/e8tc_sync.sv
// Two-flip-flop synchroniser for a level arriving from a pin.
`timescale 1ns/1ps
`default_nettype none
module e8tc_sync (
   input  wire logic clk,   // Clock.
   input  wire logic nrst,  // Synchronous reset, active low.
   input  wire logic async, // Level from outside the clock domain.
   output logic      sync   // Level after two flip-flops.
);
   logic meta_q;
   logic sync_q;

   always_ff @(posedge clk) begin
      if (!nrst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async;
         sync_q <= meta_q;
      end
   end

   assign sync = sync_q;
endmodule
`default_nettype wire

// ### design/e8tc_top.sv
// Eight-bit timer/counter with prescaler, overflow interrupt and Avalon-MM register slave.
//
// Function
// - One eight-bit count register, readable and writable by software; timer or counter.
// - Timer mode without prescaler advances the count every instruction cycle.
// - Source select bit cleared selects timer mode on the instruction clock.
// - A count write suppresses incrementing for exactly two following instruction cycles.
// - Source select bit set selects counting of external input transitions.
// - Edge select one counts falling edges, zero counts rising edges.
// - A private eight-bit prescaler, independent of any watchdog prescaler.
// - Counter state is offered as a gating source to the companion 16-bit timer.
// - Prescaler divides by 2 to 256 via a 3-bit field; bypass gives 1:1.
// - A count write with byte lane 0 enabled clears the prescaler; prescaler is not software visible.
// - Each wrap from ff to 00 sets the overflow flag; only software clears it.
// - External count edges are synchronised to the instruction clock before use.
`include "e8tc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module e8tc_top (
   input  wire logic                      clk,            // 50 MHz instruction clock.
   input  wire logic                      nrst,           // Synchronous reset, active low.
   input  wire logic [`E8TC_ADDR_W-1:0]   address,        // Avalon byte address.
   input  wire logic                      read,           // Avalon read request.
   input  wire logic                      write,          // Avalon write request.
   input  wire logic [31:0]               writedata,      // Avalon write data.
   input  wire logic [3:0]                byteenable,     // Avalon byte lanes.
   output logic [31:0]                    readdata,       // Avalon read data.
   output logic                           waitrequest,    // Avalon wait request.
   input  wire logic                      ext_count_input, // External count pin.
   input  wire logic                      cpu_sleep,      // Processor is in sleep.
   output logic                           irq,            // Level interrupt.
   output e8tc_pkg::e8tc_byte_t           count_value,    // Live count for the 16-bit timer.
   output logic                           overflow_gate   // Overflow pulse for the 16-bit timer.
);
   import e8tc_pkg::*;

   // Bus handshake state.
   logic        ack_q;
   logic        ack_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // Register state.
   e8tc_byte_t              tick_count_reg_q;
   e8tc_byte_t              tick_count_reg_d;
   logic [`E8TC_OPT_W-1:0]  option_q;
   logic [`E8TC_OPT_W-1:0]  option_d;
   logic [`E8TC_ST_W-1:0]   status_q;
   logic [`E8TC_ST_W-1:0]   status_d;
   logic [`E8TC_ST_W-1:0]   mask_q;
   logic [`E8TC_ST_W-1:0]   mask_d;
   logic [`E8TC_INH_W-1:0]  inhibit_q;
   logic [`E8TC_INH_W-1:0]  inhibit_d;
   logic                    pin_prev_q;
   logic                    pin_prev_d;
   logic                    ovf_pulse_q;
   logic                    ovf_pulse_d;

   // Decoded fields and events.
   e8tc_src_t   count_source_select;
   logic        source_edge_select;
   logic        prescaler_bypass;
   e8tc_rate_t  prescale_rate;
   logic        pin_sync;
   logic        pin_edge;
   logic        raw_tick;
   logic        tick;
   logic        inc;
   logic        wr_acc;
   logic        rd_first;
   logic        wr_low;
   logic        wr_count;
   logic        overflow;
   logic        sel_count;
   logic        sel_option;
   logic        sel_status;
   logic        sel_mask;

   assign count_source_select = e8tc_src_t'(option_q[`E8TC_OPT_SRC_BIT]);
   assign source_edge_select  = option_q[`E8TC_OPT_EDGE_BIT];
   assign prescaler_bypass    = option_q[`E8TC_OPT_BYP_BIT];
   assign prescale_rate       = option_q[`E8TC_OPT_RATE_LSB +: `E8TC_OPT_RATE_W];

   // The byte address is decoded whole, so writes to any other offset select nothing and are dropped.
   always_comb begin
      sel_count  = 1'b0;
      sel_option = 1'b0;
      sel_status = 1'b0;
      sel_mask   = 1'b0;
      case (address)
         `E8TC_OFS_COUNT: begin
            sel_count = 1'b1;
         end
         `E8TC_OFS_OPTION: begin
            sel_option = 1'b1;
         end
         `E8TC_OFS_STATUS: begin
            sel_status = 1'b1;
         end
         `E8TC_OFS_MASK: begin
            sel_mask = 1'b1;
         end
         default: begin
            sel_count = 1'b0;
         end
      endcase
   end

   // The pin is asynchronous, so it passes two flip-flops before the edge detector.
   e8tc_sync u_pin_sync (
      .clk   (clk),
      .nrst  (nrst),
      .async (ext_count_input),
      .sync  (pin_sync)
   );

   // Bus: one wait state on every access; the request completes on the second cycle.
   always_comb begin
      ack_d = (read || write) && !ack_q;
   end

   assign waitrequest = (read || write) && !ack_q;
   assign wr_acc      = write && ack_q;
   assign rd_first    = read && !ack_q;
   assign wr_low      = wr_acc && byteenable[0];
   assign wr_count    = wr_low && sel_count;

   // Read data is captured in the first cycle and stands at the completing edge.
   always_comb begin
      rdata_d = rdata_q;
      if (rd_first) begin
         rdata_d = '0;
         case (address)
            `E8TC_OFS_COUNT: begin
               rdata_d[7:0] = tick_count_reg_q;
            end
            `E8TC_OFS_OPTION: begin
               rdata_d[`E8TC_OPT_W-1:0] = option_q;
            end
            `E8TC_OFS_STATUS: begin
               rdata_d[`E8TC_ST_W-1:0] = status_q;
            end
            `E8TC_OFS_MASK: begin
               rdata_d[`E8TC_ST_W-1:0] = mask_q;
            end
            `E8TC_OFS_STATE: begin
               rdata_d[`E8TC_SS_PIN_BIT]   = pin_sync;
               rdata_d[`E8TC_SS_INH_BIT]   = (inhibit_q != '0);
               rdata_d[`E8TC_SS_SLEEP_BIT] = cpu_sleep;
            end
            default: begin
               rdata_d = '0;
            end
         endcase
      end
   end

   assign readdata = rdata_q;

   // Count clock selection and edge detection.
   always_comb begin
      pin_prev_d = pin_sync;
      if (source_edge_select) begin
         pin_edge = pin_prev_q && !pin_sync;
      end else begin
         pin_edge = !pin_prev_q && pin_sync;
      end
   end

   always_comb begin
      if (count_source_select == src_timer) begin
         raw_tick = 1'b1;
      end else begin
         raw_tick = pin_edge;
      end
      // Edges seen while frozen or held off are dropped, not queued.
      tick = raw_tick && !cpu_sleep && (inhibit_q == '0);
   end

   // The prescaler is not on the bus; only a count write reaches it.
   e8tc_prescaler #(
      .W (8)
   ) u_prescaler (
      .clk    (clk),
      .nrst   (nrst),
      .clr    (wr_count),
      .tick   (tick),
      .bypass (prescaler_bypass),
      .rate   (prescale_rate),
      .inc    (inc)
   );

   // Count, hold-off and overflow.
   always_comb begin
      tick_count_reg_d = tick_count_reg_q;
      inhibit_d        = inhibit_q;
      overflow         = 1'b0;
      if (inhibit_q != '0) begin
         inhibit_d = inhibit_q - `E8TC_INH_W'(1);
      end
      if (wr_count) begin
         // A software write wins over an increment in the same cycle.
         tick_count_reg_d = writedata[7:0];
         inhibit_d        = `E8TC_WR_INHIBIT;
      end else if (inc) begin
         tick_count_reg_d = tick_count_reg_q + 8'h01;
         overflow         = (tick_count_reg_q == 8'hff);
      end
      ovf_pulse_d = overflow;
   end

   assign count_value   = tick_count_reg_q;
   assign overflow_gate = ovf_pulse_q;

   // Option, status and mask registers.
   always_comb begin
      option_d = option_q;
      if (wr_low && sel_option) begin
         option_d = writedata[`E8TC_OPT_W-1:0];
      end
   end

   always_comb begin
      mask_d = mask_q;
      if (wr_low && sel_mask) begin
         mask_d = writedata[`E8TC_ST_W-1:0];
      end
   end

   always_comb begin
      status_d = status_q;
      if (wr_low && sel_status) begin
         status_d = status_q & ~writedata[`E8TC_ST_W-1:0];
      end
      // Set after clear, so an overflow in the clearing cycle is kept.
      if (overflow) begin
         status_d[`E8TC_ST_OVF_BIT] = 1'b1;
      end
   end

   assign irq = |(status_q & mask_q);

   // The handshake flop is high only in the second cycle of an access.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   // The previous-level flop resets low, so a pin already high when reset ends counts as one rising edge.
   always_ff @(posedge clk) begin
      if (!nrst) begin
         pin_prev_q <= 1'b0;
      end else begin
         pin_prev_q <= pin_prev_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         tick_count_reg_q <= `E8TC_COUNT_RST;
         inhibit_q        <= '0;
         ovf_pulse_q      <= 1'b0;
      end else begin
         tick_count_reg_q <= tick_count_reg_d;
         inhibit_q        <= inhibit_d;
         ovf_pulse_q      <= ovf_pulse_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         option_q <= `E8TC_OPT_RST;
      end else begin
         option_q <= option_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         mask_q <= `E8TC_MASK_RST;
      end else begin
         mask_q <= mask_d;
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         status_q <= `E8TC_STATUS_RST;
      end else begin
         status_q <= status_d;
      end
   end
endmodule
`default_nettype wire

// ### include/e8tc_consts.svh
// Offsets, field positions, reset values and timing counts of the eight-bit timer/counter.
`ifndef E8TC_CONSTS_SVH
`define E8TC_CONSTS_SVH

// Byte addresses of the registers on the Avalon-MM slave.
`define E8TC_ADDR_W        5
`define E8TC_OFS_COUNT     5'h00
`define E8TC_OFS_OPTION    5'h04
`define E8TC_OFS_STATUS    5'h08
`define E8TC_OFS_MASK      5'h0c
`define E8TC_OFS_STATE     5'h10

// Option register fields.
`define E8TC_OPT_SRC_BIT   5
`define E8TC_OPT_EDGE_BIT  4
`define E8TC_OPT_BYP_BIT   3
`define E8TC_OPT_RATE_LSB  0
`define E8TC_OPT_RATE_W    3
`define E8TC_OPT_W         6
`define E8TC_OPT_RST       6'h3f

// Status and mask fields.
`define E8TC_ST_OVF_BIT    0
`define E8TC_ST_W          1

// State register fields, read only.
`define E8TC_SS_PIN_BIT    0
`define E8TC_SS_INH_BIT    1
`define E8TC_SS_SLEEP_BIT  2

// Reset values.
`define E8TC_COUNT_RST     8'h00
`define E8TC_STATUS_RST    1'h0
`define E8TC_MASK_RST      1'h0

// Increment is held off for this many instruction cycles after a count write.
`define E8TC_WR_INHIBIT    2'h2
`define E8TC_INH_W         2

`endif

// ### include/e8tc_pkg.sv
// Types shared by the eight-bit timer/counter design.
package e8tc_pkg;
   typedef logic [7:0] e8tc_byte_t;
   typedef logic [2:0] e8tc_rate_t;
   typedef enum logic {
      src_timer,
      src_pin
   } e8tc_src_t;
endpackage

// ### tb/e8tc_checker.sv
// Port-level assertions for the eight-bit timer/counter, bound to its top module.
`include "e8tc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module e8tc_checker (
   input wire logic                    clk,           // Clock.
   input wire logic                    nrst,          // Reset, active low.
   input wire logic [`E8TC_ADDR_W-1:0] address,       // Bus address.
   input wire logic                    read,          // Bus read.
   input wire logic                    write,         // Bus write.
   input wire logic [31:0]             writedata,     // Bus write data.
   input wire logic [3:0]              byteenable,    // Bus lanes.
   input wire logic [31:0]             readdata,      // Bus read data.
   input wire logic                    waitrequest,   // Bus wait.
   input wire logic                    cpu_sleep,     // Sleep level.
   input wire logic                    irq,           // Interrupt.
   input wire e8tc_pkg::e8tc_byte_t    count_value,   // Live count.
   input wire logic                    overflow_gate  // Wrap pulse.
);
   import e8tc_pkg::*;
   logic wr_ok;
   // A write only lands on the cycle where the wait state has gone.
   assign wr_ok = write && !waitrequest;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   chk_wait_first: assert property ($rose(read || write) |-> waitrequest)
      else $error("no wait state on a new access");
   chk_wait_once: assert property (waitrequest |=> !waitrequest)
      else $error("wait state longer than one cycle");
   chk_sleep_freeze: assert property (cpu_sleep && !wr_ok |=> $stable(count_value))
      else $error("count moved during sleep");
   chk_step_one: assert property (!wr_ok |=> count_value == $past(count_value)
      || count_value == 8'($past(count_value) + 8'h01)) else $error("count jumped");
   chk_write_hold: assert property (wr_ok && address == `E8TC_OFS_COUNT && byteenable[0]
      |=> count_value == $past(writedata[7:0]) ##1 $stable(count_value) [*2])
      else $error("count write not held off two cycles");
   chk_wrap_gate: assert property ((count_value == 8'hff && !wr_ok) ##1 (count_value == 8'h00)
      |-> overflow_gate) else $error("wrap gave no gate pulse");
   chk_gate_cause: assert property (overflow_gate |-> count_value == 8'h00
      && $past(count_value) == 8'hff) else $error("gate pulse without wrap");
   chk_irq_clear: assert property ($fell(irq) |-> $past(wr_ok))
      else $error("interrupt dropped without a write");
   chk_irq_cause: assert property ($rose(irq) |-> overflow_gate || $past(wr_ok))
      else $error("interrupt rose without a cause");
   chk_unmapped_zero: assert property (read && !waitrequest && address > `E8TC_OFS_STATE
      |-> readdata == 32'h0) else $error("unmapped read not zero");
   cover property (overflow_gate);
   cover property (wr_ok && address == `E8TC_OFS_COUNT);
   cover property ($fell(irq));
endmodule
bind e8tc_top e8tc_checker chk_u (.clk, .nrst, .address, .read, .write, .writedata, .byteenable,
   .readdata, .waitrequest, .cpu_sleep, .irq, .count_value, .overflow_gate);
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the eight-bit timer/counter.
`include "e8tc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import e8tc_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
   logic        ext_count_input = 1'b0, cpu_sleep = 1'b0, waitrequest, irq, overflow_gate;
   logic [4:0]  address = 5'h00;
   logic [31:0] writedata = 32'h0, readdata, q, q2;
   logic [3:0]  byteenable = 4'h0;
   logic [7:0]  v;
   e8tc_byte_t  count_value;
   int          n_errors = 0, comparisons = 0, t;
   e8tc_top dut_u (.clk, .nrst, .address, .read, .write, .writedata, .byteenable, .readdata,
      .waitrequest, .ext_count_input, .cpu_sleep, .irq, .count_value, .overflow_gate);
   initial begin
      forever #10 clk = ~clk;
   end
   task automatic chk(input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %0t expected %h got %h", $time, e, g);
      end
   endtask
   // Waitrequest and read data are taken just after the rising edge, before the design's flops move.
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] dt, input logic [3:0] be);
      int n;
      n = 0;
      @(posedge clk);
      write <= w;
      read <= !w;
      address <= a;
      writedata <= dt;
      byteenable <= be;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      if (n >= 50) chk(32'h1, 32'h0);
      q = readdata;
      write <= 1'b0;
      read <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [31:0] dt);
      bus(1'b1, a, dt, 4'h1);
   endtask
   task automatic rd(input logic [4:0] a);
      bus(1'b0, a, 32'h0, 4'h1);
   endtask
   function automatic logic [31:0] edges(input int n, input int fall);
      return fall ? n / 2 : (n + 1) / 2;
   endfunction
   function automatic logic [31:0] scaled(input int d, input int r);
      return d >> (r + 1);
   endfunction
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #400000;
      n_errors++;
      give_verdict();
   end
   initial begin
      void'($urandom(14));
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      rd(`E8TC_OFS_OPTION);
      chk(32'h3f, q);
      rd(`E8TC_OFS_COUNT);
      chk(32'h0, q);
      wr(`E8TC_OFS_OPTION, 32'h08);
      for (int i = 0; i < 4; i++) begin
         v = (i == 0) ? 8'hfd : 8'($urandom);
         wr(`E8TC_OFS_COUNT, {24'h0, v});
         rd(`E8TC_OFS_COUNT);
         chk({24'h0, v}, q);
         rd(`E8TC_OFS_COUNT);
         chk({24'h0, v + 8'h02}, q);
         if (i == 0) begin
            rd(`E8TC_OFS_STATUS);
            chk(32'h1, q);
            wr(`E8TC_OFS_MASK, 32'h1);
            @(negedge clk);
            chk({31'h0, irq}, 32'h1);
            wr(`E8TC_OFS_STATUS, 32'h0);
            rd(`E8TC_OFS_STATUS);
            chk(32'h1, q);
            wr(`E8TC_OFS_STATUS, 32'h1);
            @(negedge clk);
            chk({31'h0, irq}, 32'h0);
            wr(`E8TC_OFS_MASK, 32'h0);
         end
      end
      // Waiting half a period past the third increment keeps the check clear of one-cycle latency.
      for (int r = 0; r < 8; r++) begin
         wr(`E8TC_OFS_OPTION, r);
         wr(`E8TC_OFS_COUNT, 32'h0);
         repeat (7 << r) @(posedge clk);
         rd(`E8TC_OFS_COUNT);
         chk(scaled(7 << r, r), q);
      end
      for (int e = 0; e < 2; e++) begin
         ext_count_input <= 1'b0;
         wr(`E8TC_OFS_OPTION, e ? 32'h38 : 32'h28);
         wr(`E8TC_OFS_COUNT, 32'h0);
         repeat (4) @(posedge clk);
         t = 2 * ($urandom % 6) + 1;
         repeat (t) begin
            repeat (2 + $urandom % 4) @(posedge clk);
            ext_count_input <= ~ext_count_input;
         end
         repeat (6) @(posedge clk);
         rd(`E8TC_OFS_COUNT);
         chk(edges(t, e), q);
      end
      wr(`E8TC_OFS_OPTION, 32'h08);
      cpu_sleep <= 1'b1;
      rd(`E8TC_OFS_COUNT);
      q2 = q;
      bus(1'b1, `E8TC_OFS_COUNT, 32'h5a, 4'h0);
      repeat (20) @(posedge clk);
      rd(`E8TC_OFS_COUNT);
      chk(q2, q);
      chk({24'h0, count_value}, q);
      rd(`E8TC_OFS_STATE);
      chk(q & 32'h4, 32'h4);
      rd(5'h14);
      chk(32'h0, q);
      cpu_sleep <= 1'b0;
      give_verdict();
   end
endmodule
`default_nettype wire
